// File: include/pin_ctrl_pkg.sv
// Constants and register map of the system pin control block.
// Notes on behaviour
// - Muxed port is two 8-bit halves, each pin with its own direction bit.
// - A pin set as input has its output driver disabled in single-chip mode and on the 8-bit mode serial pins.
// - In external bus modes the muxed port carries address then data.
// - 8-bit bus mode uses eleven address lines A10 to A0.
// - 16-bit bus mode uses sixteen address lines A15 to A0.
// - Falling edge on the non-maskable interrupt pin raises the trap request.
// - Power-down is entered only while the non-maskable interrupt pin is low.
// - Power-down request with that pin high clears power-down; normal running continues.
// - Read strobe pulses on every external instruction fetch or data read.
// - Write strobe pulses on every external data write, never on reads.
// - Address-latch-enable is driven during the address phase in muxed modes.
// - External-access pin low at reset: latch config from port and read pin.
// - External-access pin high at reset: latch config from read, latch, write pins.
// - Six-pin control port with per-pin direction carries strobes and outputs.
// - One pin outputs either the system clock divided by two or a programmable frequency.
// - Reset indication is low while any hardware, software or watchdog reset runs.
// - Reset indication stays low until end-of-initialization executes.
// - In 8-bit mode the upper port pins carry the serial channel lines.
// - Bus modes are single-chip, 16-bit/16-bit and 11-bit/8-bit multiplexed.
// - Wider bus modes leave the serial functions off the upper port pins.
package pin_ctrl_pkg;
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_DIR    = 8'h04;
	localparam logic [7:0] ADDR_OUT    = 8'h08;
	localparam logic [7:0] ADDR_PIN    = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_CMD    = 8'h14;
	localparam logic [7:0] ADDR_XFER   = 8'h18;
	localparam logic [7:0] ADDR_FDIV   = 8'h1C;
	localparam logic [7:0] ADDR_BOOT   = 8'h20;
	localparam int CTRL_MODE_LO   = 0;
	localparam int CTRL_PROGRAMMABLE_FREQ_OUT_SEL  = 2;
	localparam int CMD_END_OF_INIT_INSTR      = 0;
	localparam int CMD_POWER_DOWN_INSTR      = 1;
	localparam int CMD_SWRST      = 2;
	localparam int CMD_WDTRST     = 3;
	localparam int CMD_NMI_CLR    = 4;
	localparam int XFER_WRITE     = 16;
	localparam int XFER_FETCH     = 17;
	localparam int CP_RD          = 0;
	localparam int CP_WR          = 1;
	localparam int CP_ALE         = 2;
	localparam int CP_EA          = 3;
	localparam int CP_CLK         = 4;
	localparam int CP_RESET_INDICATION_OUT      = 5;
	localparam int ADDR8_BITS     = 11;
	localparam logic [5:0] CP_DIR_RESET = 6'h37;
	localparam logic [3:0] RESET_HOLD_CYCLES = 4'h8;
	localparam logic [1:0] SYNC_WAIT_CYCLES  = 2'h3;
	localparam logic [5:0] CP_OUT_RESET      = 6'h1F;
	localparam logic [5:0] CP_OE_N_BOOT      = 6'h1F;
	typedef enum logic [1:0] {MODE_SINGLE, MODE_BUS16, MODE_BUS8} bus_mode_t;
endpackage

// File: logic/pin_sync.sv
// Two-flop synchroniser for a group of pin inputs.
`default_nettype none
module pin_sync #(
	parameter int W = 8
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         clk_en,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] stage1;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stage1   <= '0;
			sync_out <= '0;
		end
		else if (clk_en)
		begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule
`default_nettype wire

// File: logic/ext_bus_seq.sv
// Multiplexed external bus cycle sequencer: address phase, then strobed data phase.
`default_nettype none
module ext_bus_seq
	import pin_ctrl_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	input  wire logic        start,
	input  wire logic        write,
	input  wire pin_ctrl_pkg::bus_mode_t mode,
	input  wire logic [15:0] addr,
	input  wire logic [15:0] wdata,
	input  wire logic [15:0] pin_in,
	output logic             busy,
	output logic             done,
	output logic [15:0]      rdata,
	output logic [15:0]      bus_out,
	output logic [15:0]      bus_drive,
	output logic             ale,
	output logic             rd_strobe,
	output logic             wr_strobe
);
	typedef enum logic [1:0] {S_IDLE, S_ADDR, S_DATA, S_END} seq_t;
	seq_t        state;
	logic        is_wr;
	logic [15:0] dat;
	logic [1:0]  wait_cnt;
	function automatic logic [15:0] lane_mask(input bus_mode_t m);
		lane_mask = (m == MODE_BUS8) ? 16'h00FF : 16'hFFFF;
	endfunction
	function automatic logic [15:0] addr_mask(input bus_mode_t m);
		addr_mask = (m == MODE_BUS8) ? 16'h07FF : 16'hFFFF;
	endfunction
	assign busy = (state != S_IDLE);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state     <= S_IDLE;
			is_wr     <= 1'b0;
			dat       <= 16'h0000;
			wait_cnt  <= 2'h0;
			rdata     <= 16'h0000;
			done      <= 1'b0;
			bus_out   <= 16'h0000;
			bus_drive <= 16'h0000;
			ale       <= 1'b0;
			rd_strobe <= 1'b1;
			wr_strobe <= 1'b1;
		end
		else if (clk_en)
		begin
			done <= 1'b0;
			case (state)
				S_IDLE:
				begin
					if (start && mode != MODE_SINGLE)
					begin
						state     <= S_ADDR;
						is_wr     <= write;
						dat       <= wdata & lane_mask(mode);
						bus_out   <= addr & addr_mask(mode);
						bus_drive <= addr_mask(mode);
						ale       <= 1'b1;
					end
				end
				S_ADDR:
				begin
					ale   <= 1'b0;
					wait_cnt <= 2'h0;
					state <= S_DATA;
					if (is_wr)
					begin
						bus_out   <= dat;
						bus_drive <= lane_mask(mode);
						wr_strobe <= 1'b0;
					end
					else
					begin
						bus_drive <= 16'h0000;
						rd_strobe <= 1'b0;
					end
				end
				S_DATA:
				begin
					// The strobe is held until the returned data has crossed the pin register and synchroniser.
					if (wait_cnt != SYNC_WAIT_CYCLES)
						wait_cnt <= wait_cnt + 2'h1;
					else
					begin
						if (!is_wr)
							rdata <= pin_in & lane_mask(mode);
						rd_strobe <= 1'b1;
						wr_strobe <= 1'b1;
						state     <= S_END;
					end
				end
				S_END:
				begin
					bus_drive <= 16'h0000;
					done      <= 1'b1;
					state     <= S_IDLE;
				end
				default:
					state <= S_IDLE;
			endcase
		end
	end
	property p_ale_one;
		@(posedge pclk) disable iff (!presetn) (clk_en && ale) |=> !ale;
	endproperty
	a_ale_one: assert property (p_ale_one) else $error("Latch enable longer than one cycle.");
	sequence s_data_phase;
		!ale && (!rd_strobe || !wr_strobe);
	endsequence
	property p_no_wr_on_read;
		@(posedge pclk) disable iff (!presetn) (state == S_DATA && !is_wr) |-> wr_strobe;
	endproperty
	a_no_wr_on_read: assert property (p_no_wr_on_read) else $error("Write strobe active on a read.");
	property p_ale_then_strobe;
		@(posedge pclk) disable iff (!presetn) (clk_en && state == S_ADDR) |=> s_data_phase;
	endproperty
	a_ale_then_strobe: assert property (p_ale_then_strobe) else $error("Strobe did not follow address phase.");
endmodule
`default_nettype wire

// File: logic/system_pin_control.sv
// Top of the system pin control block: APB registers, ports, boot latch, reset and NMI.
`default_nettype none
module system_pin_control
	import pin_ctrl_pkg::*;
#(
	parameter int FDIV_W = 16
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [15:0] muxed_port_in,
	output logic      [15:0] muxed_port_out,
	output logic      [15:0] muxed_port_oe_n,
	input  wire logic [5:0]  control_port_in,
	output logic      [5:0]  control_port_out,
	output logic      [5:0]  control_port_oe_n,
	input  wire logic        nmi_n_pin,
	input  wire logic [15:0] sync_serial_alt_out,
	input  wire logic [15:0] sync_serial_alt_oe,
	output logic [15:0]      sync_serial_alt_in,
	output logic             nmi_trap_req,
	output logic             power_down,
	output logic             cpu_reset_n
);
	// ************************************************************
	// Synchronised pin inputs
	// ************************************************************
	logic [15:0] port_s;
	logic [5:0]  cp_s;
	logic        nmi_s;
	logic        nmi_prev;
	pin_sync #(.W(23)) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.clk_en   (clk_en),
		.async_in ({nmi_n_pin, control_port_in, muxed_port_in}),
		.sync_out ({nmi_s, cp_s, port_s})
	);

	// ************************************************************
	// Registers
	// ************************************************************
	bus_mode_t         mode;
	logic              programmable_freq_out_sel;
	logic [15:0]       port_dir;
	logic [15:0]       port_out;
	logic [5:0]        cp_dir;
	logic [5:0]        cp_out;
	logic [FDIV_W-1:0] fdiv;
	logic [15:0]       xfer_addr;
	logic [15:0]       xfer_wdata;
	logic              xfer_start;
	logic              xfer_write;
	logic [15:0]       boot_cfg;
	logic              boot_ext;
	logic              boot_taken;
	logic              reset_active;
	logic [3:0]        rst_cnt;
	logic              wr_en;
	logic              rd_en;
	logic              bus_busy;
	logic              bus_done;
	logic [15:0]       bus_rdata;
	logic [15:0]       bus_pins;
	logic [15:0]       bus_drv;
	logic              ale;
	logic              rd_n;
	logic              wr_n;
	logic [FDIV_W-1:0] fcnt;
	logic              programmable_freq_out;
	logic              clk_div2;
	logic              rst_ind;

	assign wr_en = psel && penable && pwrite && clk_en;
	assign rd_en = psel && !penable && !pwrite && clk_en;

	// Control, direction and output-latch registers.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode       <= MODE_SINGLE;
			programmable_freq_out_sel   <= 1'b0;
			port_dir   <= 16'h0000;
			port_out   <= 16'h0000;
			cp_dir     <= CP_DIR_RESET;
			cp_out     <= 6'h00;
			fdiv       <= '0;
			xfer_addr  <= 16'h0000;
			xfer_wdata <= 16'h0000;
			xfer_start <= 1'b0;
			xfer_write <= 1'b0;
		end
		else if (clk_en)
		begin
			xfer_start <= 1'b0;
			if (wr_en)
			begin
				case (paddr)
					ADDR_CTRL:
					begin
						case (pwdata[CTRL_MODE_LO +: 2])
							2'h1:    mode <= MODE_BUS16;
							2'h2:    mode <= MODE_BUS8;
							default: mode <= MODE_SINGLE;
						endcase
						programmable_freq_out_sel <= pwdata[CTRL_PROGRAMMABLE_FREQ_OUT_SEL];
					end
					ADDR_DIR:
					begin
						port_dir <= pwdata[15:0];
						cp_dir   <= pwdata[21:16];
					end
					ADDR_OUT:
					begin
						port_out <= pwdata[15:0];
						cp_out   <= pwdata[21:16];
					end
					ADDR_FDIV: fdiv <= pwdata[FDIV_W-1:0];
					ADDR_XFER:
					begin
						if (!bus_busy)
						begin
							xfer_addr  <= pwdata[15:0];
							xfer_wdata <= xfer_wdata;
							xfer_write <= pwdata[XFER_WRITE];
							xfer_start <= 1'b1;
						end
					end
					ADDR_BOOT: xfer_wdata <= pwdata[15:0];
					default: ;
				endcase
			end
		end
	end

	// ************************************************************
	// Reset indication and boot configuration latch
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			reset_active <= 1'b1;
			rst_cnt      <= 4'h0;
			rst_ind      <= 1'b0;
			boot_taken   <= 1'b0;
			boot_cfg     <= 16'h0000;
			boot_ext     <= 1'b0;
		end
		else if (clk_en)
		begin
			if (wr_en && paddr == ADDR_CMD && (pwdata[CMD_SWRST] || pwdata[CMD_WDTRST]))
			begin
				reset_active <= 1'b1;
				rst_cnt      <= 4'h0;
				rst_ind      <= 1'b0;
				boot_taken   <= 1'b0;
			end
			else if (reset_active)
			begin
				rst_ind <= 1'b0;
				if (rst_cnt == RESET_HOLD_CYCLES)
					reset_active <= 1'b0;
				else
					rst_cnt <= rst_cnt + 4'h1;
			end
			else if (!boot_taken)
			begin
				boot_taken <= 1'b1;
				boot_ext   <= !cp_s[CP_EA];
				if (!cp_s[CP_EA])
					boot_cfg <= {port_s[15:1], cp_s[CP_RD]};
				else
					boot_cfg <= {13'h0000, cp_s[CP_WR], cp_s[CP_ALE], cp_s[CP_RD]};
			end
			else if (wr_en && paddr == ADDR_CMD && pwdata[CMD_END_OF_INIT_INSTR])
				rst_ind <= 1'b1;
		end
	end

	// ************************************************************
	// Non-maskable interrupt and power-down gating
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			// The synchroniser resets low, so the edge detector does too; otherwise a false edge follows reset.
			nmi_prev     <= 1'b0;
			nmi_trap_req <= 1'b0;
			power_down   <= 1'b0;
		end
		else if (clk_en)
		begin
			nmi_prev <= nmi_s;
			if (nmi_prev && !nmi_s)
				nmi_trap_req <= 1'b1;
			else if (wr_en && paddr == ADDR_CMD && pwdata[CMD_NMI_CLR])
				nmi_trap_req <= 1'b0;
			if (wr_en && paddr == ADDR_CMD && pwdata[CMD_POWER_DOWN_INSTR])
				power_down <= !nmi_s;
			else if (nmi_prev && !nmi_s)
				power_down <= power_down;
		end
	end

	// ************************************************************
	// External bus sequencer
	// ************************************************************
	ext_bus_seq u_bus (
		.pclk      (pclk),
		.presetn   (presetn),
		.clk_en    (clk_en),
		.start     (xfer_start),
		.write     (xfer_write),
		.mode      (mode),
		.addr      (xfer_addr),
		.wdata     (xfer_wdata),
		.pin_in    (port_s),
		.busy      (bus_busy),
		.done      (bus_done),
		.rdata     (bus_rdata),
		.bus_out   (bus_pins),
		.bus_drive (bus_drv),
		.ale       (ale),
		.rd_strobe (rd_n),
		.wr_strobe (wr_n)
	);

	// ************************************************************
	// Clock and programmable frequency output
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fcnt     <= '0;
			programmable_freq_out     <= 1'b0;
			clk_div2 <= 1'b0;
		end
		else if (clk_en)
		begin
			clk_div2 <= !clk_div2;
			if (fcnt >= fdiv)
			begin
				fcnt <= '0;
				programmable_freq_out <= !programmable_freq_out;
			end
			else
				fcnt <= fcnt + 1'b1;
		end
	end

	// ************************************************************
	// Pin drivers
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			muxed_port_out     <= 16'h0000;
			muxed_port_oe_n    <= 16'hFFFF;
			control_port_out   <= CP_OUT_RESET;
			control_port_oe_n  <= CP_OE_N_BOOT;
			sync_serial_alt_in <= 16'h0000;
		end
		else if (clk_en)
		begin
			for (int i = 0; i < 16; i++)
			begin
				if (mode == MODE_BUS8 && i >= ADDR8_BITS)
				begin
					muxed_port_out[i]  <= sync_serial_alt_out[i];
					muxed_port_oe_n[i] <= !(port_dir[i] && sync_serial_alt_oe[i]);
				end
				else if (mode != MODE_SINGLE)
				begin
					muxed_port_out[i]  <= bus_pins[i];
					muxed_port_oe_n[i] <= !bus_drv[i];
				end
				else
				begin
					muxed_port_out[i]  <= port_out[i];
					muxed_port_oe_n[i] <= !port_dir[i];
				end
			end
			sync_serial_alt_in <= (mode == MODE_BUS8) ? (port_s & 16'hF800) : 16'h0000;
			control_port_out[CP_RD]     <= (mode != MODE_SINGLE) ? rd_n : cp_out[CP_RD];
			control_port_out[CP_WR]     <= (mode != MODE_SINGLE) ? wr_n : cp_out[CP_WR];
			control_port_out[CP_ALE]    <= (mode != MODE_SINGLE) ? ale : cp_out[CP_ALE];
			control_port_out[CP_EA]     <= cp_out[CP_EA];
			control_port_out[CP_CLK]    <= programmable_freq_out_sel ? programmable_freq_out : clk_div2;
			control_port_out[CP_RESET_INDICATION_OUT] <= rst_ind;
			// Strap pins stay released until the boot configuration is latched; only the reset indication drives.
			if (reset_active || !boot_taken)
				control_port_oe_n <= CP_OE_N_BOOT;
			else
				control_port_oe_n <= ~cp_dir | (6'h01 << CP_EA);
		end
	end

	// ************************************************************
	// APB read path
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata      <= 32'h0000_0000;
			pready      <= 1'b0;
			pslverr     <= 1'b0;
			cpu_reset_n <= 1'b0;
		end
		else if (clk_en)
		begin
			cpu_reset_n <= !reset_active;
			pready      <= psel && !penable;
			pslverr     <= psel && !penable && (paddr > ADDR_BOOT || paddr[1:0] != 2'h0);
			if (rd_en)
			begin
				case (paddr)
					ADDR_CTRL:   prdata <= {29'h0, programmable_freq_out_sel, mode};
					ADDR_DIR:    prdata <= {10'h0, cp_dir, port_dir};
					ADDR_OUT:    prdata <= {10'h0, cp_out, port_out};
					ADDR_PIN:    prdata <= {9'h0, nmi_s, cp_s, port_s};
					ADDR_STATUS: prdata <= {25'h0, boot_ext, bus_done, bus_busy, power_down, nmi_trap_req, rst_ind, boot_taken};
					ADDR_XFER:   prdata <= {16'h0, bus_rdata};
					ADDR_FDIV:   prdata <= 32'(fdiv);
					ADDR_BOOT:   prdata <= {16'h0, boot_cfg};
					default:     prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	property p_pd_gate;
		@(posedge pclk) disable iff (!presetn)
			(wr_en && paddr == ADDR_CMD && pwdata[CMD_POWER_DOWN_INSTR] && nmi_s) |=> !power_down;
	endproperty
	a_pd_gate: assert property (p_pd_gate) else $error("Power-down entered with interrupt pin high.");
	property p_pd_enter;
		@(posedge pclk) disable iff (!presetn)
			(wr_en && paddr == ADDR_CMD && pwdata[CMD_POWER_DOWN_INSTR] && !nmi_s) |=> power_down;
	endproperty
	a_pd_enter: assert property (p_pd_enter) else $error("Power-down not entered.");
	property p_nmi_edge;
		@(posedge pclk) disable iff (!presetn) (clk_en && nmi_prev && !nmi_s) |=> nmi_trap_req;
	endproperty
	a_nmi_edge: assert property (p_nmi_edge) else $error("Falling interrupt edge lost.");
	property p_rst_low;
		@(posedge pclk) disable iff (!presetn) reset_active |=> !control_port_out[CP_RESET_INDICATION_OUT];
	endproperty
	a_rst_low: assert property (p_rst_low) else $error("Reset indication high during reset.");
	property p_end_of_init_instr;
		@(posedge pclk) disable iff (!presetn) $rose(rst_ind) |-> $past(wr_en && paddr == ADDR_CMD && pwdata[CMD_END_OF_INIT_INSTR]);
	endproperty
	a_end_of_init_instr: assert property (p_end_of_init_instr) else $error("Reset indication released without end of init.");
	property p_dir_in;
		@(posedge pclk) disable iff (!presetn) (clk_en && mode == MODE_SINGLE && !port_dir[0]) |=> muxed_port_oe_n[0];
	endproperty
	a_dir_in: assert property (p_dir_in) else $error("Input pin driven.");
	property p_bus8_addr;
		@(posedge pclk) disable iff (!presetn) (mode == MODE_BUS8) |-> ((bus_drv & 16'hF800) == 16'h0000);
	endproperty
	a_bus8_addr: assert property (p_bus8_addr) else $error("Upper pins used for address in 8-bit mode.");
endmodule
`default_nettype wire

// File: verif/ext_mem_model.sv
// Behavioural external memory on the multiplexed address/data bus.
`default_nettype none
module ext_mem_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [15:0] bus_out,
	input  wire logic        ale,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	output logic      [15:0] mem_data,
	output logic             mem_oe,
	output logic      [15:0] addr_q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [0:15];
	// Clocked register: the address sampled on a clock edge while latch enable is high is kept once it falls.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			addr_q <= 16'h0000;
		else if (ale)
			addr_q <= bus_out;
	end
	always_ff @(posedge pclk)
	begin
		if (!wr_n)
			mem[addr_q[3:0]] <= bus_out;
	end
	// The memory drives only while the read strobe is low; afterwards the wire is released.
	assign mem_oe = !rd_n;
	assign mem_data = mem[addr_q[3:0]];
endmodule
`default_nettype wire

// File: verif/system_pin_control_tb_top.sv
// Self-checking testbench of the system pin control block.
`default_nettype none
module system_pin_control_tb_top;
	import pin_ctrl_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 1'b0;
	logic        clk_en = 1'b1;
	logic        presetn, psel, penable, pwrite, pready, pslverr, nmi_n_pin, strap_en, mem_oe, last_err, t;
	logic        nmi_trap_req, power_down, cpu_reset_n;
	logic        prev_rd = 1'b1, prev_wr = 1'b1, prev_ale = 1'b0;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd_val;
	logic [15:0] muxed_port_in, muxed_port_out, muxed_port_oe_n, alt_out, alt_oe, alt_in, mem_data, addr_q, strap;
	logic [5:0]  control_port_in, control_port_out, control_port_oe_n, ctl_strap;
	int          n_errors = 0, samples_checked = 0, cyc = 0, n_rd = 0, n_wr = 0, n_ale = 0, r0, w0, l0;

	always #2 pclk = ~pclk;

	system_pin_control u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.muxed_port_in(muxed_port_in), .muxed_port_out(muxed_port_out), .muxed_port_oe_n(muxed_port_oe_n),
		.control_port_in(control_port_in), .control_port_out(control_port_out),
		.control_port_oe_n(control_port_oe_n), .nmi_n_pin(nmi_n_pin), .sync_serial_alt_out(alt_out),
		.sync_serial_alt_oe(alt_oe), .sync_serial_alt_in(alt_in), .nmi_trap_req(nmi_trap_req),
		.power_down(power_down), .cpu_reset_n(cpu_reset_n));

	ext_mem_model u_mem (.pclk(pclk), .presetn(presetn), .bus_out(muxed_port_out), .ale(control_port_out[CP_ALE]),
		.rd_n(control_port_out[CP_RD]), .wr_n(control_port_out[CP_WR]), .mem_data(mem_data), .mem_oe(mem_oe),
		.addr_q(addr_q));

	// Undriven port pins show the memory data while it drives, else the inverse of the output value, so a stale level never passes.
	assign muxed_port_in = strap_en ? strap : ((~muxed_port_oe_n & muxed_port_out) |
		(muxed_port_oe_n & (mem_oe ? mem_data : ~muxed_port_out)));
	assign control_port_in = (~control_port_oe_n & control_port_out) | (control_port_oe_n & ctl_strap);

	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		n_rd <= n_rd + int'(prev_rd & !control_port_out[CP_RD]);
		n_wr <= n_wr + int'(prev_wr & !control_port_out[CP_WR]);
		n_ale <= n_ale + int'(!prev_ale & control_port_out[CP_ALE]);
		prev_rd <= control_port_out[CP_RD];
		prev_wr <= control_port_out[CP_WR];
		prev_ale <= control_port_out[CP_ALE];
		if (cyc == 20000)
		begin
			n_errors = n_errors + 1;
			test_done();
		end
	end

	// ****
	// Tasks
	// ****
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd_val = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic cmd(input int b);
		apb(1'b1, ADDR_CMD, 32'h1 << b);
		repeat (3) @(posedge pclk);
	endtask

	task automatic bus_op(input logic [31:0] x, input logic [15:0] d);
		r0 = n_rd;
		w0 = n_wr;
		l0 = n_ale;
		apb(1'b1, ADDR_BOOT, {16'h0000, d});
		apb(1'b1, ADDR_XFER, x);
		repeat (2) @(posedge pclk);
		for (int i = 0; i < 30; i++)
		begin
			apb(1'b0, ADDR_STATUS, 32'h0);
			if (rd_val[4] === 1'b0)
				break;
		end
		chk("busy", 32'h0, 32'(rd_val[4]));
	endtask

	task automatic do_reset(input logic ea, input logic [15:0] s);
		presetn <= 1'b0;
		strap_en <= 1'b1;
		strap <= s;
		ctl_strap <= {2'b11, ea, 3'b111};
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (20) @(posedge pclk);
		strap_en <= 1'b0;
	endtask

	task automatic endt(input string nm);
		$display("test %s done", nm);
	endtask

	task automatic test_done;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ****
	// Tests
	// ****
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{presetn, strap_en, strap, nmi_n_pin} = {1'b0, 1'b1, 16'h0000, 1'b1};
		{alt_out, alt_oe, ctl_strap} = {16'hA800, 16'hF800, 6'h3F};
		do_reset(1'b1, 16'h0000);
		chk("port_oe_n", 16'hFFFF, muxed_port_oe_n);
		chk("rst_ind", 1'b0, control_port_out[CP_RESET_INDICATION_OUT]);
		chk("nmi_trap", 1'b0, nmi_trap_req);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("boot_ext", 1'b0, rd_val[6]);
		cmd(CMD_END_OF_INIT_INSTR);
		chk("rst_ind", 1'b1, control_port_out[CP_RESET_INDICATION_OUT]);
		for (int k = CMD_SWRST; k <= CMD_WDTRST; k++)
		begin
			cmd(k);
			chk("rst_ind", 1'b0, control_port_out[CP_RESET_INDICATION_OUT]);
			repeat (20) @(posedge pclk);
			cmd(CMD_END_OF_INIT_INSTR);
			chk("rst_ind", 1'b1, control_port_out[CP_RESET_INDICATION_OUT]);
		end
		endt("reset");
		apb(1'b1, ADDR_CTRL, 32'h0);
		apb(1'b1, ADDR_DIR, 32'h003FA55A);
		apb(1'b1, ADDR_OUT, 32'h00001234);
		repeat (3) @(posedge pclk);
		chk("port_oe_n", 16'h5AA5, muxed_port_oe_n);
		chk("port_out", 16'h0010, muxed_port_out & 16'hA55A);
		chk("ctl_oe_n", 6'h08, control_port_oe_n);
		chk("ctl_out", 3'h0, control_port_out[2:0]);
		apb(1'b0, 8'h24, 32'h0);
		chk("pslverr", 1'b1, last_err);
		clk_en <= 1'b0;
		repeat (3) @(posedge pclk);
		t = control_port_out[CP_CLK];
		@(posedge pclk);
		chk("freeze", t, control_port_out[CP_CLK]);
		clk_en <= 1'b1;
		endt("ports");
		apb(1'b1, ADDR_CTRL, 32'h1);
		bus_op(32'h00010005, 16'hBEEF);
		chk("addr16", 16'h0005, addr_q);
		chk("mem", 16'hBEEF, u_mem.mem[5]);
		chk("wr_cnt", 32'(w0 + 1), 32'(n_wr));
		chk("rd_cnt", 32'(r0), 32'(n_rd));
		chk("ale_cnt", 32'(l0 + 1), 32'(n_ale));
		bus_op(32'h00000005, 16'h0000);
		apb(1'b0, ADDR_XFER, 32'h0);
		chk("rdata", 16'hBEEF, rd_val[15:0]);
		chk("rd_cnt", 32'(r0 + 1), 32'(n_rd));
		chk("wr_cnt", 32'(w0), 32'(n_wr));
		bus_op(32'h1 << XFER_FETCH, 16'h0000);
		chk("rd_cnt", 32'(r0 + 1), 32'(n_rd));
		chk("alt_in16", 16'h0000, alt_in);
		endt("bus16");
		apb(1'b1, ADDR_CTRL, 32'h2);
		bus_op(32'h0001FFF3, 16'h00A7);
		chk("addr8", 11'h7F3, addr_q[10:0]);
		chk("mem8", 8'hA7, u_mem.mem[3][7:0]);
		chk("alt_out", 5'h15, muxed_port_out[15:11]);
		chk("alt_oe_n", 5'h0B, muxed_port_oe_n[15:11]);
		chk("alt_in", {muxed_port_in[15:11], 11'h000}, alt_in);
		@(posedge pclk);
		for (int k = 0; k < 4; k++)
		begin
			t = control_port_out[CP_CLK];
			@(posedge pclk);
			chk("clk_out", !t, control_port_out[CP_CLK]);
		end
		apb(1'b1, ADDR_FDIV, 32'h2);
		apb(1'b1, ADDR_CTRL, 32'h6);
		repeat (8) @(posedge pclk);
		t = control_port_out[CP_CLK];
		r0 = 0;
		repeat (6)
		begin
			@(posedge pclk);
			r0 = r0 + int'(control_port_out[CP_CLK] != t);
			t = control_port_out[CP_CLK];
		end
		chk("programmable_freq_out_edges", 32'h2, 32'(r0));
		endt("bus8");
		nmi_n_pin <= 1'b0;
		repeat (6) @(posedge pclk);
		chk("nmi_trap", 1'b1, nmi_trap_req);
		cmd(CMD_NMI_CLR);
		chk("nmi_trap", 1'b0, nmi_trap_req);
		nmi_n_pin <= 1'b1;
		repeat (6) @(posedge pclk);
		cmd(CMD_POWER_DOWN_INSTR);
		chk("power_down", 1'b0, power_down);
		nmi_n_pin <= 1'b0;
		repeat (6) @(posedge pclk);
		cmd(CMD_POWER_DOWN_INSTR);
		chk("power_down", 1'b1, power_down);
		endt("nmi");
		nmi_n_pin <= 1'b1;
		do_reset(1'b0, 16'h00C3);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("boot_ext", 1'b1, rd_val[6]);
		apb(1'b0, ADDR_BOOT, 32'h0);
		chk("boot_cfg", 16'h00C3, rd_val[15:0]);
		endt("boot_external");
		test_done();
	end
endmodule
`default_nettype wire
